// *** opc_osc_config.sv ***
`timescale 1ns/1ps
// Behaviour
// - Two-bit band field selects crystal frequency range.
// - Bit 5 selects slow crystal low power.
// - Type field selects source and start-up count.
// - Type field frozen while external clock drives system.
// - Monitor sets failure flag; writing one clears.
// - Set flag never blocks a new interrupt.
// - Enable bit arms monitor; flag raises NMI.
// - Monitor enable protected, only reset clears.
// - Slow RC trim loads factory value, writable.
// - PLL input select codes 00, 01, 10, 11.
// - Bit 1 picks fast DFLL reference.
// - Bit 0 picks mid DFLL reference.
// - Enable bit starts DFLL auto calibration.
// - Calibration always drives oscillator; write when disabled.
// - Low calibration bits reset mid, DFLL steps.
// - High calibration bits factory loaded, DFLL untouched.
// - Target ratio resets ideal, writable when disabled.
// - Target ratio bytes at offsets four to six.
// - Ready flag set once external source stable.
module opc_osc_config
  import opc_pkg::*;
#(
  parameter int unsigned FAIL_LIMIT = FAIL_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic sys_clk_is_ext_i,
  input wire logic ccp_unlock_i,
  input wire logic ext_clk_i,
  input wire logic slow_rc_clk_i,
  input wire logic fast_rc_clk_i,
  input wire logic mid_rc_clk_i,
  input wire logic [7:0] factory_rc_trim_i,
  input wire logic [5:0] factory_fast_trim_hi_i,
  input wire logic [5:0] factory_mid_trim_hi_i,
  output logic [1:0] crystal_freq_band_o,
  output logic slow_crystal_low_power_o,
  output logic [3:0] ext_osc_type_select_o,
  output logic ext_osc_enable_o,
  output logic ext_osc_ready_o,
  output logic osc_failure_flag_o,
  output logic osc_failure_nmi_o,
  output logic [7:0] slow_rc_trim_value_o,
  output logic [1:0] pll_input_select_o,
  output logic [4:0] pll_multiplier_o,
  output logic fast_rc_reference_select_o,
  output logic mid_rc_reference_select_o,
  output logic [12:0] fast_dfll_cal_o,
  output logic [12:0] mid_dfll_cal_o
);

  opc_state_t st_reg;
  opc_state_t st_next;

  // ****************************************************************
  // Start-up length per oscillator type
  // ****************************************************************
  // Unlisted type codes take the longest count so nothing unproven is used early.
  function automatic logic [15:0] startup_len(input logic [3:0] t);
    logic [15:0] n;
    n = STARTUP_16K;
    unique case (t)
      TYPE_EXT_CLOCK: n = STARTUP_6;
      TYPE_SLOW_CRYSTAL: n = STARTUP_16K;
      TYPE_CRYSTAL_256: n = STARTUP_256;
      TYPE_CRYSTAL_1K: n = STARTUP_1K;
      TYPE_CRYSTAL_16K: n = STARTUP_16K;
      default: n = STARTUP_16K;
    endcase
    return n;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic req;
  logic wr;
  logic [5:0] idx;
  logic [3:0] edge_seen;
  logic fail_det;
  logic [1:0] set_sel;
  logic [2:0] ofs;
  logic ref_e;
  logic tick;
  logic [7:0] rd8;

  always_comb begin
    st_next = st_reg;
    req = cyc_i & stb_i;
    wr = req & we_i & ~st_reg.ack & sel_i[0];
    idx = adr_i[7:2];
    // Index bit 5 has no DFLL set behind it, so it must not alias onto one.
    set_sel = idx[5] ? 2'h0 : idx[4:3];
    ofs = idx[2:0];
    edge_seen = st_reg.sy2 & ~st_reg.sy3;
    fail_det = 1'b0;
    ref_e = 1'b0;
    tick = 1'b0;
    rd8 = 8'h00;

    st_next.sy1 = {mid_rc_clk_i, fast_rc_clk_i, slow_rc_clk_i, ext_clk_i};
    st_next.sy2 = st_reg.sy1;
    st_next.sy3 = st_reg.sy2;
    st_next.nmi = 1'b0;
    st_next.ack = req & ~st_reg.ack;

    // Software writes come first; hardware events below override them.
    if (wr) begin
      if (idx == OSC_CTRL_IDX) begin
        st_next.xosc_en = dat_i[EXT_OSC_ENABLE_BIT];
      end
      if (idx == EXT_OSC_CONFIG_IDX) begin
        st_next.band = dat_i[BAND_LSB +: 2];
        st_next.lpm = dat_i[LOW_POWER_BIT];
        if (!sys_clk_is_ext_i) begin
          st_next.xtype = dat_i[3:0];
        end
      end
      if (idx == EXT_OSC_FAILURE_MONITOR_IDX) begin
        if (dat_i[FAIL_FLAG_BIT]) begin
          st_next.fail_flag = 1'b0;
        end
        if (dat_i[FAIL_MON_EN_BIT] && ccp_unlock_i) begin
          st_next.fdet_en = 1'b1;
        end
      end
      if (idx == SLOW_RC_TRIM_IDX) begin
        st_next.rc_trim = dat_i[7:0];
      end
      if (idx == PLL_CONFIG_IDX) begin
        st_next.pll_src = dat_i[PLL_SRC_LSB +: 2];
        st_next.pll_mul = dat_i[4:0];
      end
      if (idx == DFLL_REFERENCE_SELECT_IDX) begin
        st_next.ref_sel = dat_i[1:0];
      end
    end

    // External source start-up: count source edges up to the type's length.
    if (!st_reg.xosc_en) begin
      st_next.su_cnt = 16'h0000;
      st_next.xosc_rdy = 1'b0;
    end else if (!st_reg.xosc_rdy && edge_seen[0]) begin
      if (st_reg.su_cnt + 16'h0001 >= startup_len(st_reg.xtype)) begin
        st_next.xosc_rdy = 1'b1;
      end else begin
        st_next.su_cnt = st_reg.su_cnt + 16'h0001;
      end
    end

    // Failure monitor: too long without a source edge while running.
    if (st_reg.fdet_en && st_reg.xosc_rdy) begin
      if (edge_seen[0]) begin
        st_next.idle_cnt = 16'h0000;
      end else if (32'(st_reg.idle_cnt) >= FAIL_LIMIT - 1) begin
        fail_det = 1'b1;
        st_next.idle_cnt = 16'h0000;
      end else begin
        st_next.idle_cnt = st_reg.idle_cnt + 16'h0001;
      end
    end else begin
      st_next.idle_cnt = 16'h0000;
    end
    // The source is shut down on failure, so only a re-enable can fail again.
    if (fail_det) begin
      st_next.fail_flag = 1'b1;
      st_next.nmi = 1'b1;
      st_next.xosc_en = 1'b0;
      st_next.xosc_rdy = 1'b0;
      st_next.su_cnt = 16'h0000;
    end

    // ****************************************************************
    // DFLLs: entry 0 is the fast oscillator, entry 1 the mid one
    // ****************************************************************
    for (int i = 0; i < 2; i++) begin
      if (wr && set_sel == (i == 0 ? DFLL_FAST_SET : DFLL_MID_SET)) begin
        if (ofs == DFLL_ENABLE_REG_OFS) begin
          st_next.dfll_en[i] = dat_i[DFLL_ENABLE_BIT];
        end
        if (!st_reg.dfll_en[i]) begin
          unique case (ofs)
            DFLL_TRIM_LOW_OFS: st_next.cal_lo[i] = dat_i[6:0];
            DFLL_TRIM_HIGH_OFS: st_next.cal_hi[i] = dat_i[5:0];
            TARGET_RATIO_LOW_OFS: st_next.comp[i][7:0] = dat_i[7:0];
            TARGET_RATIO_MID_OFS: st_next.comp[i][15:8] = dat_i[7:0];
            TARGET_RATIO_HIGH_OFS: st_next.comp[i][23:16] = dat_i[7:0];
            default: ;
          endcase
        end
      end
      ref_e = st_reg.ref_sel[i == 0 ? FAST_REF_BIT : MID_REF_BIT] ? edge_seen[0] :
              edge_seen[1];
      tick = ref_e && st_reg.ref_div[i] == REF_DIV_LAST;
      if (!st_reg.dfll_en[i]) begin
        st_next.osc_cnt[i] = 24'h000000;
        st_next.ref_div[i] = 5'h00;
      end else begin
        if (ref_e) begin
          st_next.ref_div[i] = st_reg.ref_div[i] + 5'h01;
        end
        if (tick) begin
          // A slow oscillator counts short of the target, so trim upward.
          if (st_reg.osc_cnt[i] < st_reg.comp[i] && st_reg.cal_lo[i] != CAL_LOW_MAX) begin
            st_next.cal_lo[i] = st_reg.cal_lo[i] + 7'h01;
          end else if (st_reg.osc_cnt[i] > st_reg.comp[i] && st_reg.cal_lo[i] != 7'h00) begin
            st_next.cal_lo[i] = st_reg.cal_lo[i] - 7'h01;
          end
          st_next.osc_cnt[i] = {23'h000000, edge_seen[2 + i]};
        end else if (edge_seen[2 + i] && st_reg.osc_cnt[i] != 24'hffffff) begin
          st_next.osc_cnt[i] = st_reg.osc_cnt[i] + 24'h000001;
        end
      end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    unique case (idx)
      OSC_CTRL_IDX: rd8 = {4'h0, st_reg.xosc_en, 3'h0};
      OSC_STATUS_IDX: rd8 = {4'h0, st_reg.xosc_rdy, 3'h0};
      EXT_OSC_CONFIG_IDX: rd8 = {st_reg.band, st_reg.lpm, 1'b0, st_reg.xtype};
      EXT_OSC_FAILURE_MONITOR_IDX: rd8 = {6'h00, st_reg.fail_flag, st_reg.fdet_en};
      SLOW_RC_TRIM_IDX: rd8 = st_reg.rc_trim;
      PLL_CONFIG_IDX: rd8 = {st_reg.pll_src, 1'b0, st_reg.pll_mul};
      DFLL_REFERENCE_SELECT_IDX: rd8 = {6'h00, st_reg.ref_sel};
      default: rd8 = 8'h00;
    endcase
    for (int i = 0; i < 2; i++) begin
      if (set_sel == (i == 0 ? DFLL_FAST_SET : DFLL_MID_SET)) begin
        unique case (ofs)
          DFLL_ENABLE_REG_OFS: rd8 = {7'h00, st_reg.dfll_en[i]};
          DFLL_TRIM_LOW_OFS: rd8 = {1'b0, st_reg.cal_lo[i]};
          DFLL_TRIM_HIGH_OFS: rd8 = {2'h0, st_reg.cal_hi[i]};
          TARGET_RATIO_LOW_OFS: rd8 = st_reg.comp[i][7:0];
          TARGET_RATIO_MID_OFS: rd8 = st_reg.comp[i][15:8];
          TARGET_RATIO_HIGH_OFS: rd8 = st_reg.comp[i][23:16];
          default: rd8 = 8'h00;
        endcase
      end
    end
    st_next.rdat = (req & ~st_reg.ack & ~we_i) ? {24'h000000, rd8} : 32'h00000000;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.rc_trim <= factory_rc_trim_i;
      st_reg.cal_lo <= {CAL_LOW_MID, CAL_LOW_MID};
      st_reg.cal_hi <= {factory_mid_trim_hi_i, factory_fast_trim_hi_i};
      st_reg.comp <= {MID_RATIO_RST, FAST_RATIO_RST};
      st_reg.pll_src <= PLL_SRC_RST;
      st_reg.pll_mul <= PLL_MUL_RST;
      // Keep the synchronisers running so a pin left high gives no false edge on release.
      st_reg.sy1 <= {mid_rc_clk_i, fast_rc_clk_i, slow_rc_clk_i, ext_clk_i};
      st_reg.sy2 <= st_reg.sy1;
      st_reg.sy3 <= st_reg.sy2;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dat_o = st_reg.rdat;
  assign ack_o = st_reg.ack;
  assign crystal_freq_band_o = st_reg.band;
  assign slow_crystal_low_power_o = st_reg.lpm;
  assign ext_osc_type_select_o = st_reg.xtype;
  assign ext_osc_enable_o = st_reg.xosc_en;
  assign ext_osc_ready_o = st_reg.xosc_rdy;
  assign osc_failure_flag_o = st_reg.fail_flag;
  assign osc_failure_nmi_o = st_reg.nmi;
  assign slow_rc_trim_value_o = st_reg.rc_trim;
  assign pll_input_select_o = st_reg.pll_src;
  assign pll_multiplier_o = st_reg.pll_mul;
  assign fast_rc_reference_select_o = st_reg.ref_sel[FAST_REF_BIT];
  assign mid_rc_reference_select_o = st_reg.ref_sel[MID_REF_BIT];
  assign fast_dfll_cal_o = {st_reg.cal_hi[0], st_reg.cal_lo[0]};
  assign mid_dfll_cal_o = {st_reg.cal_hi[1], st_reg.cal_lo[1]};

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic wr_cfg;
  assign wr_cfg = cyc_i & stb_i & we_i & ~ack_o & sel_i[0] & adr_i[7:2] == EXT_OSC_CONFIG_IDX;

  type_lock_a: assert property (wr_cfg && sys_clk_is_ext_i |=> $stable(ext_osc_type_select_o))
    else $error("oscillator type changed while system runs from it");
  band_write_a: assert property (wr_cfg |=> crystal_freq_band_o == $past(dat_i[7:6]))
    else $error("band field did not take the written value");
  nmi_flag_a: assert property (osc_failure_nmi_o |-> osc_failure_flag_o && !ext_osc_ready_o)
    else $error("failure interrupt without the failure flag");
  nmi_pulse_a: assert property (osc_failure_nmi_o |=> !osc_failure_nmi_o)
    else $error("failure interrupt longer than one cycle");
  monitor_sticky_a: assert property (st_reg.fdet_en |=> st_reg.fdet_en)
    else $error("failure monitor enable dropped without reset");
  ready_needs_en_a: assert property (ext_osc_ready_o |-> ext_osc_enable_o)
    else $error("ready flag set with the source disabled");
  cal_high_hold_a: assert property (st_reg.dfll_en[0] |=> $stable(st_reg.cal_hi[0]))
    else $error("high calibration bits changed while the DFLL runs");
  ratio_hold_a: assert property (st_reg.dfll_en[1] |=> $stable(st_reg.comp[1]))
    else $error("target ratio changed while the DFLL runs");
  cal_step_a: assert property (st_reg.dfll_en[0] && $past(st_reg.dfll_en[0])
      |-> st_reg.cal_lo[0] == $past(st_reg.cal_lo[0])
       || st_reg.cal_lo[0] == $past(st_reg.cal_lo[0]) + 7'h01
       || st_reg.cal_lo[0] == $past(st_reg.cal_lo[0]) - 7'h01)
    else $error("low calibration bits moved by more than one step");
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("bus acknowledge held for two cycles");

  // Write strobe of the failure monitor register.
  logic wr_fail;
  assign wr_fail = wr && idx == EXT_OSC_FAILURE_MONITOR_IDX;

  type_write_a: assert property (wr_cfg && !sys_clk_is_ext_i
      |=> ext_osc_type_select_o == $past(dat_i[3:0]))
    else $error("type field missed a write");

  low_power_a: assert property (wr_cfg
      |=> slow_crystal_low_power_o == $past(dat_i[LOW_POWER_BIT]))
    else $error("low power bit missed a write");

  flag_clear_a: assert property (wr_fail && dat_i[FAIL_FLAG_BIT] && !fail_det
      |=> !osc_failure_flag_o)
    else $error("failure flag not cleared");

  flag_raise_a: assert property (fail_det
      |=> osc_failure_flag_o && osc_failure_nmi_o)
    else $error("failure gave no flag or interrupt");

  monitor_lock_a: assert property (wr_fail && !ccp_unlock_i
      |=> $stable(st_reg.fdet_en))
    else $error("monitor enable changed while protected");

  trim_write_a: assert property (wr && idx == SLOW_RC_TRIM_IDX
      |=> slow_rc_trim_value_o == $past(dat_i[7:0]))
    else $error("slow RC trim missed a write");

  pll_write_a: assert property (wr && idx == PLL_CONFIG_IDX
      |=> {pll_input_select_o, pll_multiplier_o} == $past({dat_i[PLL_SRC_LSB +: 2], dat_i[4:0]}))
    else $error("PLL setting missed a write");

  ref_write_a: assert property (wr && idx == DFLL_REFERENCE_SELECT_IDX
      |=> {fast_rc_reference_select_o, mid_rc_reference_select_o} == $past(dat_i[1:0]))
    else $error("reference select missed a write");

  dfll_start_a: assert property (wr && idx == {1'b0, DFLL_FAST_SET, DFLL_ENABLE_REG_OFS}
      |=> st_reg.dfll_en[0] == $past(dat_i[DFLL_ENABLE_BIT]))
    else $error("DFLL enable missed a write");

  cal_idle_a: assert property (!st_reg.dfll_en[1]
      && !(wr && idx == {1'b0, DFLL_MID_SET, DFLL_TRIM_LOW_OFS}) |=> $stable(st_reg.cal_lo[1]))
    else $error("low calibration moved while the DFLL is off");

endmodule

// *** opc_pkg.sv ***
package opc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 100;
  // Longest gap between external clock edges before a failure is declared.
  localparam int unsigned FAIL_TIME_NS = 100000;
  localparam int unsigned FAIL_CYCLES = (FAIL_TIME_NS * CLK_MHZ + 999) / 1000;
  // A 32.768 kHz reference divided by 32 (counts 0 to this) gives the 1.024 kHz DFLL tick.
  localparam logic [4:0] REF_DIV_LAST = 5'h1f;

  // ****************************************************************
  // Register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [5:0] OSC_CTRL_IDX = 6'h00;
  localparam logic [5:0] OSC_STATUS_IDX = 6'h01;
  localparam logic [5:0] EXT_OSC_CONFIG_IDX = 6'h02;
  localparam logic [5:0] EXT_OSC_FAILURE_MONITOR_IDX = 6'h03;
  localparam logic [5:0] SLOW_RC_TRIM_IDX = 6'h04;
  localparam logic [5:0] PLL_CONFIG_IDX = 6'h05;
  localparam logic [5:0] DFLL_REFERENCE_SELECT_IDX = 6'h06;
  // DFLL register sets: bits 4:3 of the index pick the set, bits 2:0 the register.
  localparam logic [1:0] DFLL_FAST_SET = 2'h1;
  localparam logic [1:0] DFLL_MID_SET = 2'h2;
  localparam logic [2:0] DFLL_ENABLE_REG_OFS = 3'h0;
  localparam logic [2:0] DFLL_TRIM_LOW_OFS = 3'h2;
  localparam logic [2:0] DFLL_TRIM_HIGH_OFS = 3'h3;
  localparam logic [2:0] TARGET_RATIO_LOW_OFS = 3'h4;
  localparam logic [2:0] TARGET_RATIO_MID_OFS = 3'h5;
  localparam logic [2:0] TARGET_RATIO_HIGH_OFS = 3'h6;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned EXT_OSC_ENABLE_BIT = 3;
  localparam int unsigned EXT_OSC_READY_BIT = 3;
  localparam int unsigned BAND_LSB = 6;
  localparam int unsigned LOW_POWER_BIT = 5;
  localparam int unsigned FAIL_FLAG_BIT = 1;
  localparam int unsigned FAIL_MON_EN_BIT = 0;
  localparam int unsigned PLL_SRC_LSB = 6;
  localparam int unsigned FAST_REF_BIT = 1;
  localparam int unsigned MID_REF_BIT = 0;
  localparam int unsigned DFLL_ENABLE_BIT = 0;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [3:0] TYPE_EXT_CLOCK = 4'h0;
  localparam logic [3:0] TYPE_SLOW_CRYSTAL = 4'h2;
  localparam logic [3:0] TYPE_CRYSTAL_256 = 4'h3;
  localparam logic [3:0] TYPE_CRYSTAL_1K = 4'h7;
  localparam logic [3:0] TYPE_CRYSTAL_16K = 4'hb;
  localparam logic [15:0] STARTUP_6 = 16'h0006;
  localparam logic [15:0] STARTUP_256 = 16'h0100;
  localparam logic [15:0] STARTUP_1K = 16'h0400;
  localparam logic [15:0] STARTUP_16K = 16'h4000;
  localparam logic [6:0] CAL_LOW_MID = 7'h40;
  localparam logic [6:0] CAL_LOW_MAX = 7'h7f;
  localparam logic [23:0] FAST_RATIO_RST = 24'h007a12;
  localparam logic [23:0] MID_RATIO_RST = 24'h0007a1;
  localparam logic [1:0] PLL_SRC_RST = 2'h0;
  localparam logic [4:0] PLL_MUL_RST = 5'h00;

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic ack;
    logic [31:0] rdat;
    logic xosc_en;
    logic xosc_rdy;
    logic [1:0] band;
    logic lpm;
    logic [3:0] xtype;
    logic fail_flag;
    logic fdet_en;
    logic nmi;
    logic [15:0] su_cnt;
    logic [15:0] idle_cnt;
    logic [7:0] rc_trim;
    logic [1:0] pll_src;
    logic [4:0] pll_mul;
    logic [1:0] ref_sel;
    logic [1:0] dfll_en;
    logic [1:0][6:0] cal_lo;
    logic [1:0][5:0] cal_hi;
    logic [1:0][23:0] comp;
    logic [1:0][23:0] osc_cnt;
    logic [1:0][4:0] ref_div;
  } opc_state_t;

endpackage

// *** opc_ext_osc_model.sv ***
`timescale 1ns/1ps
module opc_ext_osc_model #(
  parameter realtime HALF_NS = 37.0
) (
  input wire logic run_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic osc_o
);
  // ****************************************************************
  // External clock source
  // ****************************************************************
  // Runs at 13.5 MHz, or half that when slow, above the PLL input floor.
  // The bench picks only the external clock type and legal multipliers.
  // A stalled or disabled source holds its level, so only the monitor can see it.
  initial osc_o = 1'b0;
  always begin
    #(slow_i ? 2.0 * HALF_NS : HALF_NS);
    if (run_i && !stall_i) begin
      osc_o = ~osc_o;
    end
  end
endmodule

// *** tb_opc_osc_config.sv ***
`timescale 1ns/1ps
module tb_opc_osc_config;
  import opc_pkg::*;
  typedef struct packed {
    logic [5:0] idx;
    logic we;
    logic [7:0] wd;
    logic [7:0] exp;
  } opc_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h00000000;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, sys_ext = 1'b0, ccp = 1'b0;
  logic slow_rc = 1'b0, fast_rc = 1'b0, mid_rc = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [31:0] dat_o;
  logic ack_o, ext_clk, lp_o, en_o, rdy_o, flag_o, nmi_o, fref_o, mref_o;
  logic [1:0] band_o, pll_src_o;
  logic [3:0] type_o;
  logic [7:0] trim_o;
  logic [4:0] mul_o;
  logic [12:0] fcal_o, mcal_o;
  int failures = 0;
  int check_count = 0;
  int nmi_count = 0;
  // Reset values first, then the writable fields, then unmapped places and a status read.
  opc_row_t rows [0:31] = '{
    '{6'h04, 1'b0, 8'h00, 8'h5a}, '{6'h0a, 1'b0, 8'h00, 8'h40}, '{6'h0b, 1'b0, 8'h00, 8'h2b},
    '{6'h13, 1'b0, 8'h00, 8'h15}, '{6'h0c, 1'b0, 8'h00, 8'h12}, '{6'h0d, 1'b0, 8'h00, 8'h7a},
    '{6'h0e, 1'b0, 8'h00, 8'h00}, '{6'h14, 1'b0, 8'h00, 8'ha1}, '{6'h15, 1'b0, 8'h00, 8'h07},
    '{6'h16, 1'b0, 8'h00, 8'h00}, '{6'h02, 1'b1, 8'h00, 8'h00}, '{6'h02, 1'b1, 8'h42, 8'h42},
    '{6'h02, 1'b1, 8'h83, 8'h83}, '{6'h02, 1'b1, 8'he7, 8'he7}, '{6'h02, 1'b1, 8'hff, 8'hef},
    '{6'h02, 1'b1, 8'h0b, 8'h0b}, '{6'h05, 1'b1, 8'h1f, 8'h1f}, '{6'h05, 1'b1, 8'h5f, 8'h5f},
    '{6'h05, 1'b1, 8'h81, 8'h81}, '{6'h05, 1'b1, 8'hff, 8'hdf}, '{6'h05, 1'b1, 8'hc5, 8'hc5},
    '{6'h06, 1'b1, 8'hff, 8'h03}, '{6'h06, 1'b1, 8'h00, 8'h00}, '{6'h04, 1'b1, 8'h33, 8'h33},
    '{6'h0c, 1'b1, 8'h55, 8'h55}, '{6'h0e, 1'b1, 8'h9a, 8'h9a}, '{6'h0a, 1'b1, 8'h11, 8'h11},
    '{6'h0b, 1'b1, 8'hff, 8'h3f}, '{6'h3f, 1'b1, 8'hff, 8'h00}, '{6'h09, 1'b1, 8'hff, 8'h00},
    '{6'h07, 1'b0, 8'h00, 8'h00}, '{6'h01, 1'b0, 8'h00, 8'h00}
  };

  always #5 clk_i = ~clk_i;
  always #50 slow_rc = ~slow_rc;
  always #15 fast_rc = ~fast_rc;
  always #250 mid_rc = ~mid_rc;
  always @(posedge clk_i) begin
    if (nmi_o === 1'b1) begin
      nmi_count++;
    end
  end

  opc_ext_osc_model i_src (.run_i(en_o), .stall_i(stall), .slow_i(slow), .osc_o(ext_clk));
  opc_osc_config #(.FAIL_LIMIT(50)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .sys_clk_is_ext_i(sys_ext),
    .ccp_unlock_i(ccp), .ext_clk_i(ext_clk), .slow_rc_clk_i(slow_rc), .fast_rc_clk_i(fast_rc),
    .mid_rc_clk_i(mid_rc), .factory_rc_trim_i(8'h5a), .factory_fast_trim_hi_i(6'h2b),
    .factory_mid_trim_hi_i(6'h15), .crystal_freq_band_o(band_o),
    .slow_crystal_low_power_o(lp_o), .ext_osc_type_select_o(type_o), .ext_osc_enable_o(en_o),
    .ext_osc_ready_o(rdy_o), .osc_failure_flag_o(flag_o), .osc_failure_nmi_o(nmi_o),
    .slow_rc_trim_value_o(trim_o), .pll_input_select_o(pll_src_o), .pll_multiplier_o(mul_o),
    .fast_rc_reference_select_o(fref_o), .mid_rc_reference_select_o(mref_o),
    .fast_dfll_cal_o(fcal_o), .mid_dfll_cal_o(mcal_o)
  );

  // ****************************************************************
  // Bus and checking tasks
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] wd,
                     input logic [3:0] sl, output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= {idx, 2'b00};
    we_i <= w;
    dat_i <= {24'h000000, wd};
    sel_i <= sl;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      failures++;
      $display("BAD ack expected 1 seen timeout");
      complete_run();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(idx, 1'b1, wd, 4'h1, d);
  endtask

  task automatic rc(input string nm, input logic [5:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    bus(idx, 1'b0, 8'h00, 4'h1, d);
    check(nm, {24'h000000, exp}, {24'h000000, d});
  endtask

  // Every wait is bounded; running out of cycles ends the run as a mismatch.
  task automatic await(input int which, input int bound);
    int n;
    bit hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < bound) begin
      @(posedge clk_i);
      n++;
      case (which)
        0: hit = (rdy_o === 1'b1);
        1: hit = (nmi_o === 1'b1);
        2: hit = (fcal_o[6:0] === 7'h00);
        default: hit = (mcal_o[6:0] > 7'h40);
      endcase
    end
    if (!hit) begin
      failures++;
      $display("BAD wait %0d expected event seen timeout", which);
      complete_run();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] d;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (rows[i].we) begin
        wr(rows[i].idx, rows[i].wd);
      end
      rc($sformatf("row %0d", i), rows[i].idx, rows[i].exp);
    end
    check("pll", {25'h0, pll_src_o, mul_o}, 32'h00000065);
    check("trim pin", {24'h0, trim_o}, 32'h00000033);
    check("cal pin", {19'h0, fcal_o}, {19'h0, 6'h3f, 7'h11});
    wr(6'h06, 8'h02);
    check("ref pins", {30'h0, fref_o, mref_o}, 32'h00000002);
    wr(6'h06, 8'h01);
    check("ref pins", {30'h0, fref_o, mref_o}, 32'h00000001);
    wr(6'h06, 8'h00);
    $display("test register rows done");
    // The reference stays on the internal RC so no crystal setup is owed.
    @(posedge clk_i);
    sys_ext <= 1'b1;
    wr(6'h02, 8'h60);
    rc("frozen type", 6'h02, 8'h6b);
    check("low power", {31'h0, lp_o}, 32'h00000001);
    check("band pin", {30'h0, band_o}, 32'h00000001);
    @(posedge clk_i);
    sys_ext <= 1'b0;
    wr(6'h02, 8'h00);
    check("type pin", {28'h0, type_o}, 32'h00000000);
    bus(6'h04, 1'b1, 8'h77, 4'h0, d);
    rc("no select", 6'h04, 8'h33);
    $display("test write refusals done");
    wr(6'h00, 8'h08);
    check("early ready", {31'h0, rdy_o}, 32'h00000000);
    check("enable pin", {31'h0, en_o}, 32'h00000001);
    await(0, 300);
    rc("status", 6'h01, 8'h08);
    wr(6'h03, 8'h01);
    rc("locked enable", 6'h03, 8'h00);
    @(posedge clk_i);
    ccp <= 1'b1;
    wr(6'h03, 8'h01);
    @(posedge clk_i);
    ccp <= 1'b0;
    stall <= 1'b1;
    await(1, 300);
    repeat (2) @(posedge clk_i);
    check("ready lost", {31'h0, rdy_o}, 32'h00000000);
    rc("flag set", 6'h03, 8'h03);
    check("flag pin", {31'h0, flag_o}, 32'h00000001);
    @(posedge clk_i);
    stall <= 1'b0;
    slow <= 1'b1;
    wr(6'h00, 8'h08);
    await(0, 600);
    @(posedge clk_i);
    stall <= 1'b1;
    await(1, 300);
    repeat (2) @(posedge clk_i);
    check("nmi count", nmi_count, 32'h00000002);
    wr(6'h03, 8'h02);
    rc("flag clear", 6'h03, 8'h01);
    @(posedge clk_i);
    ccp <= 1'b1;
    wr(6'h03, 8'h00);
    @(posedge clk_i);
    ccp <= 1'b0;
    rc("sticky enable", 6'h03, 8'h01);
    $display("test failure monitor done");
    wr(6'h0c, 8'h01);
    wr(6'h0d, 8'h00);
    wr(6'h0e, 8'h00);
    wr(6'h08, 8'h01);
    rc("dfll on", 6'h08, 8'h01);
    await(2, 20000);
    repeat (700) @(posedge clk_i);
    check("low floor", {19'h0, fcal_o}, {19'h0, 6'h3f, 7'h00});
    wr(6'h0c, 8'hff);
    rc("ratio locked", 6'h0c, 8'h01);
    wr(6'h0a, 8'h22);
    rc("cal locked", 6'h0a, 8'h00);
    wr(6'h08, 8'h00);
    wr(6'h0a, 8'h22);
    rc("manual cal", 6'h0a, 8'h22);
    check("manual pin", {19'h0, fcal_o}, {19'h0, 6'h3f, 7'h22});
    wr(6'h10, 8'h01);
    await(3, 3000);
    check("mid high", {26'h0, mcal_o[12:7]}, 32'h00000015);
    $display("test dfll done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("trim reset", {24'h0, trim_o}, 32'h0000005a);
    check("cal reset", {19'h0, fcal_o}, {19'h0, 6'h2b, 7'h40});
    rc("enable reset", 6'h03, 8'h00);
    rc("ratio reset", 6'h0c, 8'h12);
    $display("test second reset done");
    complete_run();
  end
endmodule
